// ### ufbt_mem.sv
// Transmit FIFO storage with a registered read port.
`timescale 1ns/1ps
module ufbt_mem
(
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [ufbt_pkg::UFBT_PTR_W-1:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [ufbt_pkg::UFBT_PTR_W-1:0] rd_addr_i,
   output logic [7:0] rd_data_o
);
   import ufbt_pkg::*;

   logic [7:0] store [UFBT_FIFO_DEPTH];

   always_ff @(posedge clk_i)
   begin
      if (wr_en_i)
      begin
         store[wr_addr_i] <= wr_data_i;
      end
   end

   // Read data is held until the next read so the consumer may take it late.
   always_ff @(posedge clk_i)
   begin
      if (rd_en_i)
      begin
         rd_data_o <= store[rd_addr_i];
      end
   end

endmodule

// ### ufbt_pkg.sv
// Constants, register map and types for the fractional rate generator and transmitter.
package ufbt_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] UFBT_ADDR_HOLDING = 8'h00;
   localparam logic [7:0] UFBT_ADDR_DIV_LOW = 8'h04;
   localparam logic [7:0] UFBT_ADDR_DIV_HIGH = 8'h08;
   localparam logic [7:0] UFBT_ADDR_FRACTION = 8'h0c;
   localparam logic [7:0] UFBT_ADDR_LINE_CTL = 8'h10;
   localparam logic [7:0] UFBT_ADDR_FIFO_CTL = 8'h14;
   localparam logic [7:0] UFBT_ADDR_MODEM_CTL = 8'h18;
   localparam logic [7:0] UFBT_ADDR_LINE_STATUS = 8'h1c;

   // ==========================================================
   // Reset values
   localparam logic [7:0] UFBT_RST_DIV_LOW = 8'h01;
   localparam logic [7:0] UFBT_RST_DIV_HIGH = 8'h00;
   localparam logic [5:0] UFBT_RST_FRACTION = 6'h00;
   localparam logic [7:0] UFBT_RST_LINE_CTL = 8'h03;
   localparam logic [7:0] UFBT_RST_MODEM_CTL = 8'h00;
   localparam logic UFBT_RST_FIFO_EN = 1'b0;

   // ==========================================================
   // Field positions
   localparam int UFBT_MCR_PRESCALE_BIT = 7;
   localparam int UFBT_FCR_FIFO_EN_BIT = 0;
   localparam int UFBT_LSR_HOLD_EMPTY_BIT = 5;
   localparam int UFBT_LSR_TX_EMPTY_BIT = 6;
   localparam int UFBT_FRAC_LSB = 0;
   localparam int UFBT_FRAC_MSB = 3;
   localparam int UFBT_RATIO_LSB = 4;
   localparam int UFBT_RATIO_MSB = 5;

   // ==========================================================
   // Sampling ratio codes and counts
   localparam logic [1:0] UFBT_RATIO_16X = 2'h0;
   localparam logic [1:0] UFBT_RATIO_8X = 2'h1;
   localparam logic [1:0] UFBT_RATIO_4X = 2'h2;
   localparam logic [4:0] UFBT_CLKS_16X = 5'h10;
   localparam logic [4:0] UFBT_CLKS_8X = 5'h08;
   localparam logic [4:0] UFBT_CLKS_4X = 5'h04;
   localparam logic [1:0] UFBT_PRESCALE_LAST = 2'h3;

   // ==========================================================
   // FIFO geometry
   localparam int UFBT_FIFO_DEPTH = 32;
   localparam int UFBT_PTR_W = 5;
   localparam logic [5:0] UFBT_FIFO_CAP = 6'h20;
   localparam logic [5:0] UFBT_HOLD_CAP = 6'h01;
   localparam logic [2:0] UFBT_MIN_DATA_BITS = 3'h5;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [2:0] unused;
      logic even_parity;
      logic parity_en;
      logic two_stop;
      logic [1:0] word_len;
   } ufbt_line_ctl_t;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_LOAD,
      TX_START,
      TX_DATA,
      TX_PARITY,
      TX_STOP
   } ufbt_tx_state_t;

   function automatic logic [4:0] ufbt_ratio(input logic [1:0] sel);
      logic [4:0] clks;
      clks = UFBT_CLKS_16X;
      case (sel)
         UFBT_RATIO_8X: clks = UFBT_CLKS_8X;
         UFBT_RATIO_4X: clks = UFBT_CLKS_4X;
         default: clks = UFBT_CLKS_16X;
      endcase
      return clks;
   endfunction

endpackage

// ### ufbt_remote.sv
// Remote serial receiver model that decodes characters seen on the transmit line.
`timescale 1ns/1ps
module ufbt_remote
(
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic [7:0] bit_clks_i,
   input wire logic [3:0] nbits_i,
   input wire logic par_en_i,
   output logic got_o,
   output logic [10:0] char_o
);
   // ==========================================================
   // Decoder
   // Sampling at mid-bit keeps a cycle of skew on the line harmless.
   initial got_o = 1'b0;
   always
   begin
      @(negedge txd_i);
      char_o = 11'h000;
      repeat (bit_clks_i / 2) @(posedge clk_i);
      char_o[10] = txd_i;
      for (int i = 0; i < nbits_i; i++)
      begin
         repeat (bit_clks_i) @(posedge clk_i);
         char_o[i] = txd_i;
      end
      if (par_en_i)
      begin
         repeat (bit_clks_i) @(posedge clk_i);
         char_o[8] = txd_i;
      end
      repeat (bit_clks_i) @(posedge clk_i);
      char_o[9] = txd_i;
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
   end
endmodule

// ### ufbt_top.sv
// Fractional rate generator and serial transmit path with a Wishbone register slave.
`timescale 1ns/1ps
module ufbt_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic txd_o,
   output logic sample_tick_o
);
   import ufbt_pkg::*;

   // ==========================================================
   // Register bus slave
   logic [7:0] divisor_low_byte;
   logic [7:0] divisor_high_byte;
   logic [5:0] divisor_fraction_and_sampling;
   ufbt_line_ctl_t line_ctl;
   logic fifo_en;
   logic [7:0] modem_control_reg;
   logic [7:0] line_status_reg;
   logic [31:0] next_dat;
   logic req;
   logic wr_take;
   logic wr_lane0;
   logic flush;
   logic push;
   logic pop;
   logic hold_empty;
   logic tx_empty;
   logic [5:0] fill;
   logic [5:0] cap;
   ufbt_tx_state_t state;

   assign req = cyc_i && stb_i;
   // A write lands on the edge where the master sees ack high.
   assign wr_take = req && we_i && ack_o;
   assign wr_lane0 = wr_take && sel_i[0];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
      end
      else
      begin
         ack_o <= req && !ack_o;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_o <= 32'h0;
      end
      else if (req && !ack_o)
      begin
         dat_o <= we_i ? 32'h0 : next_dat;
      end
   end

   always_comb
   begin
      next_dat = 32'h0;
      case (adr_i)
         UFBT_ADDR_DIV_LOW: next_dat = {24'h0, divisor_low_byte};
         UFBT_ADDR_DIV_HIGH: next_dat = {24'h0, divisor_high_byte};
         UFBT_ADDR_FRACTION: next_dat = {26'h0, divisor_fraction_and_sampling};
         UFBT_ADDR_LINE_CTL: next_dat = {24'h0, line_ctl};
         UFBT_ADDR_FIFO_CTL: next_dat = {31'h0, fifo_en};
         UFBT_ADDR_MODEM_CTL: next_dat = {24'h0, modem_control_reg};
         UFBT_ADDR_LINE_STATUS: next_dat = {24'h0, line_status_reg};
         default: next_dat = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         divisor_low_byte <= UFBT_RST_DIV_LOW;
         divisor_high_byte <= UFBT_RST_DIV_HIGH;
         divisor_fraction_and_sampling <= UFBT_RST_FRACTION;
      end
      else if (wr_lane0)
      begin
         if (adr_i == UFBT_ADDR_DIV_LOW)
         begin
            divisor_low_byte <= dat_i[7:0];
         end
         if (adr_i == UFBT_ADDR_DIV_HIGH)
         begin
            divisor_high_byte <= dat_i[7:0];
         end
         if (adr_i == UFBT_ADDR_FRACTION)
         begin
            divisor_fraction_and_sampling <= dat_i[UFBT_RATIO_MSB:0];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         line_ctl <= UFBT_RST_LINE_CTL;
         modem_control_reg <= UFBT_RST_MODEM_CTL;
         fifo_en <= UFBT_RST_FIFO_EN;
      end
      else if (wr_lane0)
      begin
         if (adr_i == UFBT_ADDR_LINE_CTL)
         begin
            line_ctl <= {3'h0, dat_i[4:0]};
         end
         if (adr_i == UFBT_ADDR_MODEM_CTL)
         begin
            modem_control_reg <= dat_i[7:0];
         end
         if (adr_i == UFBT_ADDR_FIFO_CTL)
         begin
            fifo_en <= dat_i[UFBT_FCR_FIFO_EN_BIT];
         end
      end
   end

   // Changing FIFO mode discards queued bytes; mixing the two depths would corrupt order.
   assign flush = wr_lane0 && (adr_i == UFBT_ADDR_FIFO_CTL)
      && (dat_i[UFBT_FCR_FIFO_EN_BIT] != fifo_en);

   // ==========================================================
   // Prescaler and rate generator
   logic [1:0] pre_cnt;
   logic pre_tick;
   logic [15:0] int_div;
   logic [15:0] eff_div;
   logic [3:0] frac;
   logic [3:0] frac_acc;
   logic extra;
   logic [16:0] brg_cnt;
   logic [16:0] period_last;
   logic [4:0] frac_sum;
   logic samp_tick;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pre_cnt <= 2'h0;
      end
      else
      begin
         pre_cnt <= pre_cnt + 2'h1;
      end
   end

   assign pre_tick = modem_control_reg[UFBT_MCR_PRESCALE_BIT] ?
      (pre_cnt == UFBT_PRESCALE_LAST) : 1'b1;

   assign int_div = {divisor_high_byte, divisor_low_byte};
   assign frac = divisor_fraction_and_sampling[UFBT_FRAC_MSB:UFBT_FRAC_LSB];
   // A zero integer divisor is run as one so the generator never stalls.
   assign eff_div = (int_div == 16'h0) ? 16'h1 : int_div;
   assign period_last = {1'b0, eff_div} - 17'h1 + {16'h0, extra};
   assign samp_tick = pre_tick && (brg_cnt >= period_last);
   assign frac_sum = {1'b0, frac_acc} + {1'b0, frac};
   assign sample_tick_o = samp_tick;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         brg_cnt <= 17'h0;
         frac_acc <= 4'h0;
         extra <= 1'b0;
      end
      else if (samp_tick)
      begin
         brg_cnt <= 17'h0;
         frac_acc <= frac_sum[3:0];
         extra <= frac_sum[4];
      end
      else if (pre_tick)
      begin
         brg_cnt <= brg_cnt + 17'h1;
      end
   end

   // ==========================================================
   // Holding register and transmit FIFO
   logic [UFBT_PTR_W-1:0] wptr;
   logic [UFBT_PTR_W-1:0] rptr;
   logic [7:0] rd_byte;

   assign cap = fifo_en ? UFBT_FIFO_CAP : UFBT_HOLD_CAP;
   assign push = wr_lane0 && (adr_i == UFBT_ADDR_HOLDING) && (fill < cap) && !flush;
   assign pop = (state == TX_IDLE) && (fill != 6'h0) && !flush;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || flush)
      begin
         wptr <= '0;
         rptr <= '0;
         fill <= 6'h0;
      end
      else
      begin
         if (push)
         begin
            wptr <= wptr + 5'h1;
         end
         if (pop)
         begin
            rptr <= rptr + 5'h1;
         end
         if (push && !pop)
         begin
            fill <= fill + 6'h1;
         end
         else if (pop && !push)
         begin
            fill <= fill - 6'h1;
         end
      end
   end

   ufbt_mem u_mem
   (
      .clk_i(clk_i),
      .wr_en_i(push),
      .wr_addr_i(wptr),
      .wr_data_i(dat_i[7:0]),
      .rd_en_i(pop),
      .rd_addr_i(rptr),
      .rd_data_o(rd_byte)
   );

   assign hold_empty = (fill == 6'h0);
   assign tx_empty = hold_empty && (state == TX_IDLE);
   // status in bits 5 and 6
   always_comb
   begin
      line_status_reg = 8'h0;
      line_status_reg[UFBT_LSR_HOLD_EMPTY_BIT] = hold_empty;
      line_status_reg[UFBT_LSR_TX_EMPTY_BIT] = tx_empty;
   end

   // ==========================================================
   // Transmit shifter
   logic [7:0] transmit_shifter;
   logic [3:0] sub;
   logic [3:0] ratio_last;
   logic [2:0] bits_left;
   logic parity;
   logic bit_end;

   assign ratio_last = 4'(ufbt_ratio(
      divisor_fraction_and_sampling[UFBT_RATIO_MSB:UFBT_RATIO_LSB]) - 5'h1);
   assign bit_end = samp_tick && (sub >= ratio_last);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sub <= 4'h0;
      end
      else if (state == TX_IDLE || state == TX_LOAD || bit_end)
      begin
         sub <= 4'h0;
      end
      else if (samp_tick)
      begin
         sub <= sub + 4'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= TX_IDLE;
         txd_o <= 1'b1;
         transmit_shifter <= 8'h0;
         bits_left <= 3'h0;
         parity <= 1'b0;
      end
      else
      begin
         case (state)
            TX_IDLE:
            begin
               txd_o <= 1'b1;
               if (pop)
               begin
                  state <= TX_LOAD;
               end
            end
            TX_LOAD:
            begin
               if (samp_tick)
               begin
                  transmit_shifter <= rd_byte;
                  txd_o <= 1'b0;
                  bits_left <= UFBT_MIN_DATA_BITS + {1'b0, line_ctl.word_len} - 3'h1;
                  state <= TX_START;
               end
            end
            TX_START:
            begin
               if (bit_end)
               begin
                  txd_o <= transmit_shifter[0];
                  parity <= transmit_shifter[0];
                  transmit_shifter <= {1'b0, transmit_shifter[7:1]};
                  state <= TX_DATA;
               end
            end
            TX_DATA:
            begin
               if (bit_end)
               begin
                  if (bits_left != 3'h0)
                  begin
                     txd_o <= transmit_shifter[0];
                     parity <= parity ^ transmit_shifter[0];
                     transmit_shifter <= {1'b0, transmit_shifter[7:1]};
                     bits_left <= bits_left - 3'h1;
                  end
                  else
                  begin
                     bits_left <= {2'h0, line_ctl.two_stop};
                     if (line_ctl.parity_en)
                     begin
                        txd_o <= line_ctl.even_parity ? parity : !parity;
                        state <= TX_PARITY;
                     end
                     else
                     begin
                        txd_o <= 1'b1;
                        state <= TX_STOP;
                     end
                  end
               end
            end
            TX_PARITY:
            begin
               if (bit_end)
               begin
                  txd_o <= 1'b1;
                  state <= TX_STOP;
               end
            end
            TX_STOP:
            begin
               if (bit_end)
               begin
                  if (bits_left == 3'h0)
                  begin
                     state <= TX_IDLE;
                  end
                  else
                  begin
                     bits_left <= bits_left - 3'h1;
                  end
               end
            end
            default:
            begin
               state <= TX_IDLE;
               txd_o <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Assertions
   logic [4:0] bit_ticks;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || bit_end)
      begin
         bit_ticks <= 5'h0;
      end
      else if (samp_tick && state != TX_IDLE && state != TX_LOAD)
      begin
         bit_ticks <= bit_ticks + 5'h1;
      end
   end

   property p_reset_div;
      @(posedge clk_i) $past(rst_i) |-> (int_div == 16'h1 && frac == 4'h0);
   endproperty
   a_reset_div: assert property (p_reset_div) else $error("divisor not one after reset");

   property p_prescale;
      @(posedge clk_i) disable iff (rst_i)
         (modem_control_reg[UFBT_MCR_PRESCALE_BIT] && pre_tick) [*1] ##1
         modem_control_reg[UFBT_MCR_PRESCALE_BIT] [*3] |-> !$past(pre_tick);
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler ticks too often");

   property p_bit_len;
      @(posedge clk_i) disable iff (rst_i)
         (bit_end && state != TX_LOAD && state != TX_IDLE) |-> (bit_ticks == 5'(ratio_last));
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit time wrong length");

   property p_idle_high;
      @(posedge clk_i) disable iff (rst_i) (state == TX_IDLE) |=> txd_o;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not idle high");

   property p_start_low;
      @(posedge clk_i) disable iff (rst_i) (state == TX_START) |-> !txd_o;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");

   property p_first_bit;
      @(posedge clk_i) disable iff (rst_i)
         (state == TX_START && bit_end) |=> (txd_o == $past(transmit_shifter[0]));
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first data bit not bit zero");

   property p_holding_read;
      @(posedge clk_i) disable iff (rst_i)
         (ack_o && !we_i && adr_i == UFBT_ADDR_HOLDING) |-> (dat_o == 32'h0);
   endproperty
   a_holding_read: assert property (p_holding_read) else $error("holding read not zero");

   property p_push_ptr;
      @(posedge clk_i) disable iff (rst_i)
         push |=> (wptr == $past(wptr) + 5'h1) && !hold_empty;
   endproperty
   a_push_ptr: assert property (p_push_ptr) else $error("write pointer not advanced");

   property p_fill_cap;
      @(posedge clk_i) disable iff (rst_i) fill <= cap;
   endproperty
   a_fill_cap: assert property (p_fill_cap) else $error("queue exceeds depth");

   property p_tx_empty;
      @(posedge clk_i) disable iff (rst_i)
         line_status_reg[UFBT_LSR_TX_EMPTY_BIT] |-> line_status_reg[UFBT_LSR_HOLD_EMPTY_BIT]
            && state == TX_IDLE;
   endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("tx empty while busy");

   property p_load_empty;
      @(posedge clk_i) disable iff (rst_i)
         (!fifo_en && pop && !push) |=> line_status_reg[UFBT_LSR_HOLD_EMPTY_BIT];
   endproperty
   a_load_empty: assert property (p_load_empty) else $error("holding empty not set");

   c_char_sent: cover property (@(posedge clk_i) disable iff (rst_i)
      state == TX_STOP ##1 state == TX_IDLE);
   c_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i) fill == UFBT_FIFO_CAP);
   c_parity: cover property (@(posedge clk_i) disable iff (rst_i) state == TX_PARITY);
   c_fraction: cover property (@(posedge clk_i) disable iff (rst_i) samp_tick && extra);

endmodule

// ### ufbt_top_bench.sv
// Self-checking bench for the rate generator and serial transmitter.
`timescale 1ns/1ps
module ufbt_top_bench;
   import ufbt_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, txd_o, sample_tick_o, got, par_en;
   logic [7:0] adr_i, bit_clks, lc;
   logic [3:0] sel_i, nbits;
   logic [31:0] dat_i, dat_o;
   logic [10:0] char_w;
   logic [7:0] rd_q[$];
   logic [10:0] ch_q[$];
   logic [47:0] rt [5] = '{48'h00_00_03_00_0030, 48'h00_00_02_08_0028, 48'h00_01_00_00_1000,
      48'h80_00_02_00_0080, 48'h00_00_01_0f_001f};
   logic [31:0] tt [3] = '{32'h00_01_10_07, 32'h10_01_08_1b, 32'h20_03_0c_08};
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 32'h003e;

   ufbt_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .txd_o(txd_o), .sample_tick_o(sample_tick_o));
   ufbt_remote u_remote (.clk_i(clk_i), .txd_i(txd_o), .bit_clks_i(bit_clks), .nbits_i(nbits),
      .par_en_i(par_en), .got_o(got), .char_o(char_w));

   // ==========================================================
   // Clock, watchdog and shared tasks
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial
   begin
      #200000;
      n_mismatch++;
      close_out();
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_char(input logic [10:0] g, input logic [10:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_span(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 8'h00);
   endtask

   task automatic cfg(input logic [7:0] l);
      wb(1'b1, UFBT_ADDR_LINE_CTL, l);
      lc = l;
      par_en = l[3];
      nbits = 4'h5 + {2'b00, l[1:0]};
   endtask

   task automatic send(input logic [7:0] d);
      logic [7:0] m;
      m = d & (8'hff >> (4'h8 - nbits));
      ch_q.push_back({1'b0, 1'b1, par_en & (lc[4] ? ^m : ~^m), m});
      wb(1'b1, UFBT_ADDR_HOLDING, d);
   endtask

   task automatic measure(input logic [15:0] e);
      int k;
      int n;
      k = 0;
      n = 0;
      while (k < 18)
      begin
         @(posedge clk_i);
         if (k >= 2)
            n++;
         if (sample_tick_o === 1'b1)
            k++;
      end
      check_span(n, {16'h0, e});
   endtask

   task automatic drain();
      while (ch_q.size() != 0)
         @(posedge clk_i);
      repeat (2 * bit_clks) @(posedge clk_i);
      rd(UFBT_ADDR_LINE_STATUS, 8'h60);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // Result monitor: every answer is matched with the oldest note
   always @(posedge clk_i)
   begin
      if (ack_o === 1'b1 && we_i === 1'b0)
         check(dat_o, {24'h0, rd_q.pop_front()});
      if (got === 1'b1)
         check_char(char_w, ch_q.pop_front());
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'hf;
      dat_i = 32'h0;
      cfg_init: begin lc = 8'h03; par_en = 1'b0; nbits = 4'h8; bit_clks = 8'h10; end
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(UFBT_ADDR_DIV_LOW, 8'h01);
      rd(UFBT_ADDR_DIV_HIGH, 8'h00);
      rd(UFBT_ADDR_FRACTION, 8'h00);
      rd(UFBT_ADDR_HOLDING, 8'h00);
      rd(8'hfc, 8'h00);
      measure(16'h0010);
      $display("reset test done");
      // host splits divisor into bytes and fraction
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b1, UFBT_ADDR_MODEM_CTL, rt[i][47:40]);
         wb(1'b1, UFBT_ADDR_DIV_HIGH, rt[i][39:32]);
         wb(1'b1, UFBT_ADDR_DIV_LOW, rt[i][31:24]);
         wb(1'b1, UFBT_ADDR_FRACTION, rt[i][23:16]);
         measure(rt[i][15:0]);
      end
      wb(1'b1, UFBT_ADDR_FRACTION, 8'hff);
      rd(UFBT_ADDR_FRACTION, 8'h3f);
      $display("rate test done");
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b1, UFBT_ADDR_FRACTION, tt[i][31:24]);
         wb(1'b1, UFBT_ADDR_DIV_LOW, tt[i][23:16]);
         bit_clks = tt[i][15:8];
         cfg(tt[i][7:0]);
         send(8'($random(seed)));
         repeat (3) @(posedge clk_i);
         rd(UFBT_ADDR_LINE_STATUS, 8'h20);
         send(8'($random(seed)));
         drain();
      end
      $display("character test done");
      wb(1'b1, UFBT_ADDR_FIFO_CTL, 8'h01);
      for (int i = 0; i < 5; i++)
         send(8'($random(seed)));
      rd(UFBT_ADDR_LINE_STATUS, 8'h00);
      drain();
      $display("queue test done");
      close_out();
   end
endmodule
